// [rtl/compare_output_fault_trigger_ctrl.sv]
/*
 * Output compare unit with fault handling, inversion, cascade, trigger/sync
 * control and an APB register slave with interrupt.
 * Assumes all inputs synchronous to sys_clk; fault_in and trig_src are levels
 * or pulses sampled each edge; the pad combines cmp_out with cmp_oe_n.
 */
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "compare_ctrl_map.svh"
module compare_output_fault_trigger_ctrl
    import compare_ctrl_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int NUM_SRC = 32,
    parameter compare_ctrl_pkg::source_code_t SEQ_SRC_CODE = 5'h1f
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_SRC-1:0] trig_src,
    input wire logic sequencer_trig,
    input wire logic fault_in,
    output logic cmp_out,
    output logic cmp_oe_n,
    output logic trig_out,
    output logic irq
);
    logic unit_enable_q;
    logic [15:0] control_two_q;
    logic [WIDTH-1:0] period_q;
    logic [WIDTH-1:0] duty_q;
    logic unit_fault_flag_q;
    logic [`IRQ_WIDTH-1:0] irq_status_q;
    logic [`IRQ_WIDTH-1:0] irq_mask_q;
    logic [31:0] prdata_q;
    logic cmp_out_q;
    logic oe_n_q;
    logic trig_out_q;
    unit_state_t state_q;

    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic mapped;
    logic [31:0] rd_mux;
    logic [NUM_SRC-1:0] src_vec;
    source_code_t src_sel;
    logic src_hit;
    logic trig_mode;
    logic run_flag;
    logic hold_clear;
    logic sync_clear;
    logic [WIDTH-1:0] count;
    logic period_start;
    logic raw_cmp;
    logic leave_fault;
    logic [`IRQ_WIDTH-1:0] irq_events;

    // apb phases; zero wait states, so pready stays high
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign pready = 1'b1;
    assign mapped = (paddr == `OFS_CONTROL_ONE) || (paddr == `OFS_CONTROL_TWO) ||
                    (paddr == `OFS_PERIOD) || (paddr == `OFS_DUTY) ||
                    (paddr == `OFS_FAULT_FLAG) || (paddr == `OFS_IRQ_STATUS) ||
                    (paddr == `OFS_IRQ_MASK);
    assign pslverr = access && !mapped;
    assign prdata = prdata_q;

    // field views of control two
    assign src_sel = control_two_q[`SRC_SEL_HI:`SRC_SEL_LO];
    assign trig_mode = control_two_q[`BIT_TRIGGER_OR_SYNC_SELECT];
    assign run_flag = control_two_q[`BIT_TRIGGER_RUN_FLAG];

    // source vector; the sequencer line owns one fixed code
    always_comb begin
        src_vec = trig_src;
        src_vec[SEQ_SRC_CODE] = sequencer_trig;
        src_vec[`SRC_NONE] = 1'b0;
    end
    // self-selection is software's duty, not checked here
    assign src_hit = src_vec[src_sel];

    // trigger mode holds the timer until the run flag is set
    assign hold_clear = trig_mode && !run_flag;
    assign sync_clear = !trig_mode && src_hit;

    compare_timebase #(
        .WIDTH(WIDTH)
    ) u_timebase (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .run(unit_enable_q),
        .hold_clear(hold_clear),
        .sync_clear(sync_clear),
        .wide(control_two_q[`BIT_CASCADE_PAIR_ENABLE]),
        .period(period_q),
        .count_q(count),
        .period_start(period_start)
    );

    // narrow mode compares only the low half of the duty value
    always_comb begin
        if (control_two_q[`BIT_CASCADE_PAIR_ENABLE]) begin
            raw_cmp = count < duty_q;
        end else begin
            raw_cmp = count[`HALF_WIDTH-1:0] < duty_q[`HALF_WIDTH-1:0];
        end
    end

    // read mux; reserved positions come back zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `OFS_CONTROL_ONE: rd_mux[`BIT_UNIT_ENABLE] = unit_enable_q;
            `OFS_CONTROL_TWO: rd_mux[15:0] = control_two_q;
            `OFS_PERIOD: rd_mux[WIDTH-1:0] = period_q;
            `OFS_DUTY: rd_mux[WIDTH-1:0] = duty_q;
            `OFS_FAULT_FLAG: rd_mux[0] = unit_fault_flag_q;
            `OFS_IRQ_STATUS: rd_mux[`IRQ_WIDTH-1:0] = irq_status_q;
            `OFS_IRQ_MASK: rd_mux[`IRQ_WIDTH-1:0] = irq_mask_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data captured in setup so it is stable through access
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    // enable, period, duty and mask registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            unit_enable_q <= 1'b0;
            period_q <= '0;
            duty_q <= '0;
            irq_mask_q <= '0;
        end else if (wr) begin
            if (paddr == `OFS_CONTROL_ONE) begin
                unit_enable_q <= pwdata[`BIT_UNIT_ENABLE];
            end
            if (paddr == `OFS_PERIOD) begin
                period_q <= pwdata[WIDTH-1:0];
            end
            if (paddr == `OFS_DUTY) begin
                duty_q <= pwdata[WIDTH-1:0];
            end
            if (paddr == `OFS_IRQ_MASK) begin
                irq_mask_q <= pwdata[`IRQ_WIDTH-1:0];
            end
        end
    end

    // control two; the run flag is also set by hardware, and the set wins
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            control_two_q <= `CONTROL_TWO_RESET;
        end else begin
            if (wr && paddr == `OFS_CONTROL_TWO) begin
                control_two_q <= pwdata[15:0] & `CONTROL_TWO_WMASK;
            end
            if (!unit_enable_q) begin
                control_two_q[`BIT_TRIGGER_RUN_FLAG] <= 1'b0;
            end else if (trig_mode && src_hit) begin
                control_two_q[`BIT_TRIGGER_RUN_FLAG] <= 1'b1;
            end
        end
    end

    // fault flag: set by a fault, cleared by writing one; set wins
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            unit_fault_flag_q <= 1'b0;
        end else if (fault_in) begin
            unit_fault_flag_q <= 1'b1;
        end else if (wr && paddr == `OFS_FAULT_FLAG && pwdata[0]) begin
            unit_fault_flag_q <= 1'b0;
        end
    end

    // exit from fault waits on a new period and, in hold mode, the flag
    always_comb begin
        leave_fault = period_start && !fault_in;
        if (control_two_q[`BIT_FAULT_HOLD_SELECT]) begin
            leave_fault = leave_fault && !unit_fault_flag_q;
        end
        // hold select clear needs no software step
    end

    // unit state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= UNIT_OFF;
        end else begin
            case (state_q)
                UNIT_OFF: begin
                    if (unit_enable_q) begin
                        state_q <= fault_in ? UNIT_FAULT : UNIT_RUN;
                    end
                end
                UNIT_RUN: begin
                    if (!unit_enable_q) begin
                        state_q <= UNIT_OFF;
                    end else if (fault_in) begin
                        state_q <= UNIT_FAULT;
                    end
                end
                UNIT_FAULT: begin
                    if (!unit_enable_q) begin
                        state_q <= UNIT_OFF;
                    end else if (leave_fault) begin
                        state_q <= UNIT_RUN;
                    end
                end
                default: state_q <= UNIT_OFF;
            endcase
        end
    end

    // pin value and enable; fault level bypasses the inverter
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmp_out_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            case (state_q)
                UNIT_FAULT: begin
                    cmp_out_q <= control_two_q[`BIT_FAULT_DRIVE_LEVEL];
                    oe_n_q <= control_two_q[`BIT_FAULT_FLOAT_ENABLE] ||
                              control_two_q[`BIT_OUTPUT_FLOAT];
                end
                UNIT_RUN: begin
                    cmp_out_q <= raw_cmp ^ control_two_q[`BIT_OUTPUT_INVERT];
                    oe_n_q <= control_two_q[`BIT_OUTPUT_FLOAT];
                end
                default: begin
                    // idle output is the inactive level, still inverted
                    cmp_out_q <= control_two_q[`BIT_OUTPUT_INVERT];
                    oe_n_q <= control_two_q[`BIT_OUTPUT_FLOAT];
                end
            endcase
        end
    end
    assign cmp_out = cmp_out_q;
    assign cmp_oe_n = oe_n_q;

    // trigger out: a pulse at each period start and on switch-off
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_out_q <= 1'b0;
        end else begin
            trig_out_q <= period_start || (state_q != UNIT_OFF && !unit_enable_q);
        end
    end
    assign trig_out = trig_out_q;

    // interrupt events; a status read clears only the bits it reported
    assign irq_events[`IRQ_PERIOD] = period_start;
    assign irq_events[`IRQ_FAULT] = fault_in && state_q != UNIT_FAULT;
    assign irq_events[`IRQ_TRIGGER] = trig_mode && src_hit && !run_flag;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_status_q <= '0;
        end else if (rd && paddr == `OFS_IRQ_STATUS) begin
            // read data was taken in setup; an event after it must survive
            irq_status_q <= (irq_status_q & ~prdata_q[`IRQ_WIDTH-1:0]) | irq_events;
        end else begin
            irq_status_q <= irq_status_q | irq_events;
        end
    end

    // level interrupt, combinational from sticky bits and mask
    assign irq = |(irq_status_q & irq_mask_q);
endmodule : compare_output_fault_trigger_ctrl
`default_nettype wire

// [rtl/compare_ctrl_map.svh]
/*
 * Register offsets, field positions and reset values of the compare unit.
 * Assumes byte addresses on a 32-bit APB; each register is one aligned word.
 */
`ifndef COMPARE_CTRL_MAP_SVH
`define COMPARE_CTRL_MAP_SVH

// byte offsets
`define OFS_CONTROL_ONE 8'h00
`define OFS_CONTROL_TWO 8'h04
`define OFS_PERIOD 8'h08
`define OFS_DUTY 8'h0c
`define OFS_FAULT_FLAG 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK 8'h18

// control one
`define BIT_UNIT_ENABLE 0

// control two fields
`define BIT_FAULT_HOLD_SELECT 15
`define BIT_FAULT_DRIVE_LEVEL 14
`define BIT_FAULT_FLOAT_ENABLE 13
`define BIT_OUTPUT_INVERT 12
`define BIT_CASCADE_PAIR_ENABLE 8
`define BIT_TRIGGER_OR_SYNC_SELECT 7
`define BIT_TRIGGER_RUN_FLAG 6
`define BIT_OUTPUT_FLOAT 5
`define SRC_SEL_HI 4
`define SRC_SEL_LO 0
`define CONTROL_TWO_RESET 16'h000c
`define CONTROL_TWO_WMASK 16'hf1ff

// interrupt status bits
`define IRQ_PERIOD 0
`define IRQ_FAULT 1
`define IRQ_TRIGGER 2
`define IRQ_WIDTH 3

// source code that selects nothing
`define SRC_NONE 5'h00
`define HALF_WIDTH 16

`endif

// [rtl/compare_ctrl_pkg.sv]
/*
 * Types shared by the compare unit files.
 * Assumes compare_ctrl_map.svh supplies the numeric layout.
 */
package compare_ctrl_pkg;
    typedef enum logic [1:0] {
        UNIT_OFF,
        UNIT_RUN,
        UNIT_FAULT
    } unit_state_t;
    typedef logic [4:0] source_code_t;
endpackage : compare_ctrl_pkg

// [rtl/compare_timebase.sv]
/*
 * Timebase counter of the compare unit: 16 or 32 bits, held, synced.
 * Assumes sys_clk domain; hold/sync inputs may be levels held for many cycles.
 */
`timescale 1ns/1ps
`default_nettype none
`include "compare_ctrl_map.svh"
module compare_timebase #(
    parameter int WIDTH = 32
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic run,
    input wire logic hold_clear,
    input wire logic sync_clear,
    input wire logic wide,
    input wire logic [WIDTH-1:0] period,
    output logic [WIDTH-1:0] count_q,
    output logic period_start
);
    logic [WIDTH-1:0] limit;
    logic at_end;

    // narrow mode looks only at the low half of the period
    assign limit = wide ? period : {{(WIDTH-`HALF_WIDTH){1'b0}}, period[`HALF_WIDTH-1:0]};
    assign at_end = (count_q >= limit);
    assign period_start = run && !hold_clear && (at_end || sync_clear);

    // counter; held at zero while waiting for a trigger
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
        end else if (!run || hold_clear || sync_clear || at_end) begin
            count_q <= '0;
        end else begin
            count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule : compare_timebase
`default_nettype wire

// [verification/cmp_ctrl_monitor.sv]
/*
 * Concurrent checks of the compare unit, seen from its top-level ports.
 * Assumes software writes come only over APB, so a shadow of them is exact.
 */
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl_monitor (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic fault_in,
    input wire logic cmp_out,
    input wire logic cmp_oe_n,
    input wire logic trig_out,
    input wire logic irq
);
    logic en_s;
    logic [15:0] ctl2_s;
    logic [2:0] mask_s;
    logic acc;
    assign acc = psel && penable;
    // shadow of software settings, updated at the edge where a write lands
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_s <= 1'b0;
            ctl2_s <= 16'h000c;
            mask_s <= 3'h0;
        end else if (acc && pwrite) begin
            if (paddr == 8'h00) en_s <= pwdata[0];
            if (paddr == 8'h04) ctl2_s <= pwdata[15:0];
            if (paddr == 8'h18) mask_s <= pwdata[2:0];
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    // settings held still so a write in mid-fault cannot race the pin
    sequence s_fault_held;
        (en_s && fault_in && $stable(ctl2_s)) [*3];
    endsequence
    property p_unmapped_err;
        acc && paddr > 8'h18 |-> pslverr;
    endproperty
    property p_unmapped_rd;
        acc && !pwrite && paddr > 8'h18 |-> prdata == 32'h0;
    endproperty
    property p_rd_reserved;
        acc && !pwrite && paddr == 8'h04 |-> prdata[11:9] == 3'h0 && prdata[31:16] == 16'h0;
    endproperty
    property p_fault_level;
        s_fault_held |-> cmp_out == ctl2_s[14];
    endproperty
    property p_fault_oe;
        s_fault_held |-> cmp_oe_n == (ctl2_s[13] | ctl2_s[5]);
    endproperty
    property p_float;
        (ctl2_s[5] && $stable(ctl2_s)) [*2] |-> cmp_oe_n;
    endproperty
    property p_off_pulse;
        $fell(en_s) |-> ##[0:2] trig_out;
    endproperty
    property p_irq_mask;
        mask_s == 3'h0 |-> !irq;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("no error on unmapped access");
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
    a_rd_reserved: assert property (p_rd_reserved) else $error("unused control bits read set");
    a_fault_level: assert property (p_fault_level) else $error("fault level wrong");
    a_fault_oe: assert property (p_fault_oe) else $error("fault pin direction wrong");
    a_float: assert property (p_float) else $error("pin driven while floated");
    a_off_pulse: assert property (p_off_pulse) else $error("no pulse at switch-off");
    a_irq_mask: assert property (p_irq_mask) else $error("irq with all sources masked");
endmodule : cmp_ctrl_monitor
bind compare_output_fault_trigger_ctrl cmp_ctrl_monitor mon (.sys_clk, .arst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pslverr, .fault_in, .cmp_out, .cmp_oe_n, .trig_out, .irq);
`default_nettype wire

// [verification/compare_output_fault_trigger_ctrl_tb_top.sv]
/*
 * Self-checking bench of the compare unit: APB master plus pin stimulus.
 * Assumes default parameters: sequencer at source code 31.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t mismatch", $time); end end
module compare_output_fault_trigger_ctrl_tb_top;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] trig_src = 32'h0;
    logic sequencer_trig = 1'b0;
    logic fault_in = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, cmp_out, cmp_oe_n, trig_out, irq;
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int cmp_count = 0;
    compare_output_fault_trigger_ctrl uut (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .trig_src, .sequencer_trig, .fault_in, .cmp_out, .cmp_oe_n, .trig_out, .irq);
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic give_verdict();
        $display("checks %0d, bad %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    // one APB transfer; request held until pready is seen high
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin n_fail++; $display("BAD %0t no pready", $time); give_verdict(); end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // wait on a settled pin value: 0 cmp_out, 1 cmp_oe_n, 2 trig_out
    task automatic wait_pin(input int sel, input logic v);
        int n;
        n = 0;
        cmp_count++;
        do begin
            @(negedge sys_clk);
            n++;
        end while ((sel == 0 ? cmp_out : sel == 1 ? cmp_oe_n : trig_out) !== v && n < 40);
        if (n >= 40) begin n_fail++; $display("BAD %0t pin wait", $time); give_verdict(); end
    endtask : wait_pin
    task automatic t_regs();
        xfer(8'h04, 1'b0, 32'h0);
        `CHK(rd, 32'h0000_000c)
        xfer(8'h04, 1'b1, 32'hffff_ffff);
        xfer(8'h04, 1'b0, 32'h0);
        `CHK(rd & 32'hffff_ffbf, 32'h0000_f1bf)
        xfer(8'h1c, 1'b0, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        xfer(8'h04, 1'b1, 32'h0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_pins();
        xfer(8'h08, 1'b1, 32'h0000_ffff); // long period keeps period pulses off trig_out
        xfer(8'h0c, 1'b1, 32'h0);
        xfer(8'h04, 1'b1, 32'h0000_1000);
        xfer(8'h00, 1'b1, 32'h1);
        wait_pin(0, 1'b1);
        `CHK(cmp_oe_n, 1'b0)
        xfer(8'h04, 1'b1, 32'h0);
        wait_pin(0, 1'b0);
        xfer(8'h04, 1'b1, 32'h0000_0020);
        wait_pin(1, 1'b1);
        xfer(8'h00, 1'b1, 32'h0);
        wait_pin(2, 1'b1);
        $display("test pins done");
    endtask : t_pins
    task automatic t_fault();
        xfer(8'h08, 1'b1, 32'h8);
        xfer(8'h18, 1'b1, 32'h2);
        xfer(8'h04, 1'b1, 32'h0000_4000);
        xfer(8'h00, 1'b1, 32'h1);
        fault_in <= 1'b1;
        wait_pin(0, 1'b1);
        `CHK(irq, 1'b1)
        xfer(8'h14, 1'b0, 32'h0);
        @(negedge sys_clk);
        `CHK({rd[1], irq}, 2'b10)
        xfer(8'h04, 1'b1, 32'h0000_6000);
        wait_pin(1, 1'b1);
        @(posedge sys_clk);
        fault_in <= 1'b0;
        wait_pin(1, 1'b0);
        xfer(8'h04, 1'b1, 32'h0000_c000);
        fault_in <= 1'b1;
        wait_pin(0, 1'b1);
        @(posedge sys_clk);
        fault_in <= 1'b0;
        repeat (20) @(negedge sys_clk);
        `CHK(cmp_out, 1'b1)
        xfer(8'h10, 1'b1, 32'h1);
        wait_pin(0, 1'b0);
        xfer(8'h00, 1'b1, 32'h0);
        $display("test fault done");
    endtask : t_fault
    task automatic t_trig();
        xfer(8'h04, 1'b1, 32'h0000_0083); // plain source 3, never the unit itself
        xfer(8'h00, 1'b1, 32'h1);
        xfer(8'h04, 1'b0, 32'h0);
        `CHK(rd[6], 1'b0)
        trig_src[3] <= 1'b1;
        @(posedge sys_clk);
        trig_src[3] <= 1'b0;
        xfer(8'h04, 1'b0, 32'h0);
        `CHK(rd[6], 1'b1)
        xfer(8'h00, 1'b1, 32'h0);
        xfer(8'h04, 1'b1, 32'h0000_009f);
        xfer(8'h00, 1'b1, 32'h1);
        trig_src[31] <= 1'b1; // sequencer code must ignore this plain source
        @(posedge sys_clk);
        trig_src[31] <= 1'b0;
        xfer(8'h04, 1'b0, 32'h0);
        `CHK(rd[6], 1'b0)
        sequencer_trig <= 1'b1;
        @(posedge sys_clk);
        sequencer_trig <= 1'b0;
        xfer(8'h04, 1'b0, 32'h0);
        `CHK(rd[6], 1'b1)
        xfer(8'h00, 1'b1, 32'h0);
        $display("test trig done");
    endtask : t_trig
    // mask gating, sync mode, hold at zero in trigger mode, cascade width
    task automatic t_mode();
        logic seen;
        seen = 1'b0;
        xfer(8'h18, 1'b1, 32'h0);
        @(negedge sys_clk);
        `CHK(irq, 1'b0) // fault status still pending, now masked
        xfer(8'h08, 1'b1, 32'h0000_ffff);
        xfer(8'h04, 1'b1, 32'h0000_0003); // sync to source 3, not the unit itself
        xfer(8'h00, 1'b1, 32'h1);
        trig_src[3] <= 1'b1;
        @(posedge sys_clk);
        trig_src[3] <= 1'b0;
        wait_pin(2, 1'b1);
        xfer(8'h00, 1'b1, 32'h0); // no unit listens here, nothing to deselect first
        xfer(8'h08, 1'b1, 32'h0000_0004);
        xfer(8'h04, 1'b1, 32'h0000_0083);
        xfer(8'h00, 1'b1, 32'h1);
        repeat (20) begin
            @(negedge sys_clk);
            seen = seen | trig_out;
        end
        `CHK(seen, 1'b0)
        trig_src[3] <= 1'b1;
        @(posedge sys_clk);
        trig_src[3] <= 1'b0;
        wait_pin(2, 1'b1);
        xfer(8'h00, 1'b1, 32'h0);
        xfer(8'h08, 1'b1, 32'h0001_0004);
        xfer(8'h04, 1'b1, 32'h0);
        xfer(8'h00, 1'b1, 32'h1);
        wait_pin(2, 1'b1);
        xfer(8'h04, 1'b1, 32'h0000_0100);
        @(negedge sys_clk); // a pulse launched with the old width may still stand
        seen = 1'b0;
        repeat (20) begin
            @(negedge sys_clk);
            seen = seen | trig_out;
        end
        `CHK(seen, 1'b0)
        xfer(8'h00, 1'b1, 32'h0);
        $display("test mode done");
    endtask : t_mode
    initial begin
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_regs();
        t_pins();
        t_fault();
        t_trig();
        t_mode();
        give_verdict();
    end
endmodule : compare_output_fault_trigger_ctrl_tb_top
`default_nettype wire
